// ### core/scp_core.sv
// Purpose: six channel pwm generator with dead time and pin routing
// Assumes: i_clk 20 MHz, synchronous active-low reset, software port
// Notes: gpio levels come from logic on the same clock
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module scp_core import scp_pkg::*; #(
    parameter int CHANNELS = 6,
    parameter int CNT_W = 16,
    parameter int DT_W = 9
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [5:0] i_gpio_pin,
    input wire logic [5:0] i_gpio_alt,
    output logic [5:0] o_pin,
    output logic [5:0] o_alt_pin,
    output logic [5:0] o_pwm
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] alt_pin_sel;
        logic [7:0] pin_sel;
        logic [7:0] control_one;
        logic [5:0][CNT_W-1:0] duty;
        logic [CNT_W-1:0] period;
        logic [7:0] dt_enable;
        logic [7:0] dt_count;
        scp_ta_t ta_state;
        logic [2:0] ta_timer;
        logic [6:0] prescale;
        logic [CNT_W-1:0] cnt;
        logic count_down;
        logic [5:0] raw;
        logic [5:0] target_prev;
        logic [2:0][DT_W-1:0] dt_cnt;
        logic [2:0] dt_busy;
        logic [5:0] pwm;
        logic [5:0] pin;
        logic [5:0] alt_pin;
        logic [7:0] rdata;
    } scp_state_t;

    scp_state_t s_reg;
    scp_state_t s_next;

    function automatic logic [CNT_W-1:0] put_byte(input logic [CNT_W-1:0] word,
                                                  input logic high, input logic [7:0] data);
        logic [CNT_W-1:0] res;
        res = word;
        if (high) begin
            res[CNT_W-1:8] = data;
        end else begin
            res[7:0] = data;
        end
        return res;
    endfunction

    logic tick;
    logic [1:0] mode;
    logic [DT_W-1:0] dt_load;
    logic [5:0] target;
    logic [3:0] duty_idx;
    logic protected_ok;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        mode = s_reg.control_one[SCP_MODE_LSB +: 2];
        dt_load = {s_reg.dt_enable[SCP_DT_MSB_BIT], s_reg.dt_count};
        duty_idx = 4'(i_addr - SCP_ADDR_DUTY_BASE);
        protected_ok = (s_reg.ta_state == SCP_TA_OPEN);
        // prescaler: ratio two to the power of the field
        tick = (s_reg.prescale == 7'((8'h01 << s_reg.control_one[SCP_DIV_LSB +: 3]) - 8'h01));
        s_next.prescale = tick ? 7'h00 : 7'(s_reg.prescale + 7'h01);

        // timed access: aa then 55, then one protected write inside the window
        case (s_reg.ta_state)
            SCP_TA_LOCKED: begin
                if (i_wr && i_addr == SCP_ADDR_TIMED_ACCESS && i_wdata == SCP_UNLOCK_FIRST) begin
                    s_next.ta_state = SCP_TA_HALF;
                end
            end
            SCP_TA_HALF: begin
                if (i_wr && i_addr == SCP_ADDR_TIMED_ACCESS && i_wdata == SCP_UNLOCK_SECOND) begin
                    s_next.ta_state = SCP_TA_OPEN;
                    s_next.ta_timer = SCP_UNLOCK_WINDOW;
                end else begin
                    s_next.ta_state = SCP_TA_LOCKED;
                end
            end
            SCP_TA_OPEN: begin
                s_next.ta_timer = s_reg.ta_timer - 3'h1;
                if (s_reg.ta_timer == 3'h1 || i_wr) begin
                    s_next.ta_state = SCP_TA_LOCKED;
                end
            end
            default: begin
                s_next.ta_state = SCP_TA_LOCKED;
            end
        endcase

        // register writes
        if (i_wr) begin
            if (i_addr == SCP_ADDR_ALT_PIN_SEL) begin
                s_next.alt_pin_sel = i_wdata & SCP_ALT_PIN_MASK;
            end
            if (i_addr == SCP_ADDR_PIN_SEL) begin
                s_next.pin_sel = i_wdata & SCP_PIN_MASK;
            end
            if (i_addr == SCP_ADDR_CONTROL_ONE) begin
                s_next.control_one = i_wdata;
            end
            if (i_addr >= SCP_ADDR_DUTY_BASE && i_addr <= SCP_ADDR_DUTY_LAST) begin
                s_next.duty[duty_idx[3:1]] = put_byte(s_reg.duty[duty_idx[3:1]], duty_idx[0], i_wdata);
            end
            if (i_addr == SCP_ADDR_PERIOD_LOW) begin
                s_next.period = put_byte(s_reg.period, 1'b0, i_wdata);
            end
            if (i_addr == SCP_ADDR_PERIOD_HIGH) begin
                s_next.period = put_byte(s_reg.period, 1'b1, i_wdata);
            end
            // locked writes are dropped silently
            if (i_addr == SCP_ADDR_DT_ENABLE && protected_ok) begin
                s_next.dt_enable = i_wdata & SCP_DT_ENABLE_MASK;
            end
            if (i_addr == SCP_ADDR_DT_COUNT && protected_ok) begin
                s_next.dt_count = i_wdata;
            end
        end

        // register reads, data only in the following cycle
        s_next.rdata = 8'h00;
        if (i_rd) begin
            if (i_addr == SCP_ADDR_ALT_PIN_SEL) begin
                s_next.rdata = s_reg.alt_pin_sel;
            end else if (i_addr == SCP_ADDR_PIN_SEL) begin
                s_next.rdata = s_reg.pin_sel;
            end else if (i_addr == SCP_ADDR_CONTROL_ONE) begin
                s_next.rdata = s_reg.control_one;
            end else if (i_addr >= SCP_ADDR_DUTY_BASE && i_addr <= SCP_ADDR_DUTY_LAST) begin
                s_next.rdata = duty_idx[0] ? s_reg.duty[duty_idx[3:1]][15:8] : s_reg.duty[duty_idx[3:1]][7:0];
            end else if (i_addr == SCP_ADDR_PERIOD_LOW) begin
                s_next.rdata = s_reg.period[7:0];
            end else if (i_addr == SCP_ADDR_PERIOD_HIGH) begin
                s_next.rdata = s_reg.period[15:8];
            end else if (i_addr == SCP_ADDR_COUNT_LOW) begin
                s_next.rdata = s_reg.cnt[7:0];
            end else if (i_addr == SCP_ADDR_COUNT_HIGH) begin
                s_next.rdata = s_reg.cnt[15:8];
            end else if (i_addr == SCP_ADDR_DT_ENABLE) begin
                s_next.rdata = s_reg.dt_enable;
            end else if (i_addr == SCP_ADDR_DT_COUNT) begin
                s_next.rdata = s_reg.dt_count;
            end
        end

        // ****************************************
        // period counter
        // ****************************************
        if (tick) begin
            if (!s_reg.control_one[SCP_TYPE_BIT]) begin
                s_next.count_down = 1'b0;
                // sawtooth: period plus one steps per cycle
                s_next.cnt = (s_reg.cnt >= s_reg.period) ? '0 : CNT_W'(s_reg.cnt + 1'b1);
            end else if (!s_reg.count_down) begin
                // triangle: twice period steps per cycle
                if (s_reg.cnt >= s_reg.period) begin
                    s_next.count_down = (s_reg.period != '0);
                    s_next.cnt = (s_reg.period == '0) ? '0 : CNT_W'(s_reg.cnt - 1'b1);
                end else begin
                    s_next.cnt = CNT_W'(s_reg.cnt + 1'b1);
                end
            end else begin
                if (s_reg.cnt == '0) begin
                    s_next.count_down = 1'b0;
                    s_next.cnt = (s_reg.period == '0) ? '0 : CNT_W'(s_reg.cnt + 1'b1);
                end else begin
                    s_next.cnt = CNT_W'(s_reg.cnt - 1'b1);
                end
            end
        end

        // high below duty: set at zero or down match, cleared at up match
        for (int n = 0; n < CHANNELS; n++) begin
            s_next.raw[n] = (s_reg.cnt < s_reg.duty[n]);
        end

        // ****************************************
        // output modes and dead time
        // ****************************************
        target = s_reg.raw;
        for (int p = 0; p < 3; p++) begin
            case (mode)
                SCP_MODE_COMPL: target[2*p+1] = ~s_reg.raw[2*p];
                SCP_MODE_SYNC: target[2*p+1] = s_reg.raw[2*p];
                default: target[2*p+1] = s_reg.raw[2*p+1];
            endcase
        end
        s_next.target_prev = target;
        for (int p = 0; p < 3; p++) begin
            if (mode == SCP_MODE_COMPL && s_reg.dt_enable[p]) begin
                if ((target[2*p] & ~s_reg.target_prev[2*p]) | (target[2*p+1] & ~s_reg.target_prev[2*p+1])) begin
                    s_next.dt_busy[p] = 1'b1;
                    s_next.dt_cnt[p] = dt_load;
                end else if (s_reg.dt_busy[p]) begin
                    if (s_reg.dt_cnt[p] == '0) begin
                        s_next.dt_busy[p] = 1'b0;
                    end else begin
                        s_next.dt_cnt[p] = DT_W'(s_reg.dt_cnt[p] - 1'b1);
                    end
                end
            end else begin
                s_next.dt_busy[p] = 1'b0;
                s_next.dt_cnt[p] = '0;
            end
            // falling edges pass at once, rising ones wait
            s_next.pwm[2*p] = target[2*p] & ~s_next.dt_busy[p];
            s_next.pwm[2*p+1] = target[2*p+1] & ~s_next.dt_busy[p];
        end

        // ****************************************
        // pin routing
        // ****************************************
        for (int n = 0; n < CHANNELS; n++) begin
            s_next.pin[n] = s_reg.pin_sel[n] ? s_reg.pwm[n] : i_gpio_pin[n];
            s_next.alt_pin[n] = s_reg.alt_pin_sel[n] ? s_reg.pwm[n] : i_gpio_alt[n];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            s_reg <= '0;
            s_reg.ta_state <= SCP_TA_LOCKED;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_rdata = s_reg.rdata;
    assign o_pin = s_reg.pin;
    assign o_alt_pin = s_reg.alt_pin;
    assign o_pwm = s_reg.pwm;
endmodule
`default_nettype wire

// ### core/scp_pkg.sv
// Purpose: constants for the six channel pwm core
// Assumes: 8-bit register port, one clock
// Notes: offsets are register addresses on the plain port
package scp_pkg;
    localparam logic [7:0] SCP_ADDR_ALT_PIN_SEL = 8'hc6;
    localparam logic [7:0] SCP_ADDR_TIMED_ACCESS = 8'hc7;
    localparam logic [7:0] SCP_ADDR_PIN_SEL = 8'hde;
    localparam logic [7:0] SCP_ADDR_CONTROL_ONE = 8'hdf;
    localparam logic [7:0] SCP_ADDR_DUTY_BASE = 8'he0;
    localparam logic [7:0] SCP_ADDR_DUTY_LAST = 8'heb;
    localparam logic [7:0] SCP_ADDR_PERIOD_LOW = 8'hec;
    localparam logic [7:0] SCP_ADDR_PERIOD_HIGH = 8'hed;
    localparam logic [7:0] SCP_ADDR_COUNT_LOW = 8'hee;
    localparam logic [7:0] SCP_ADDR_COUNT_HIGH = 8'hef;
    localparam logic [7:0] SCP_ADDR_DT_ENABLE = 8'hf9;
    localparam logic [7:0] SCP_ADDR_DT_COUNT = 8'hfa;
    localparam logic [7:0] SCP_RESET_BYTE = 8'h00;
    localparam logic [7:0] SCP_ALT_PIN_MASK = 8'h2e;
    localparam logic [7:0] SCP_PIN_MASK = 8'h3f;
    localparam logic [7:0] SCP_DT_ENABLE_MASK = 8'h17;
    localparam int SCP_TYPE_BIT = 4;
    localparam int SCP_DT_MSB_BIT = 4;
    localparam int SCP_MODE_LSB = 6;
    localparam int SCP_DIV_LSB = 0;
    localparam logic [7:0] SCP_UNLOCK_FIRST = 8'haa;
    localparam logic [7:0] SCP_UNLOCK_SECOND = 8'h55;
    localparam logic [2:0] SCP_UNLOCK_WINDOW = 3'h4;
    typedef enum {SCP_TA_LOCKED, SCP_TA_HALF, SCP_TA_OPEN} scp_ta_t;
    localparam logic [1:0] SCP_MODE_INDEP = 2'h0;
    localparam logic [1:0] SCP_MODE_COMPL = 2'h1;
    localparam logic [1:0] SCP_MODE_SYNC = 2'h2;
endpackage

// ### bench/scp_core_sva.sv
// Purpose: port checks for scp_core
// Assumes: bound in tb_top, synchronous active-low reset
// Notes: shadows control and select bytes from the write port
`timescale 1ns/1ps
`default_nettype none
module scp_core_chk import scp_pkg::*; (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [5:0] i_gpio_pin,
    input wire logic [5:0] i_gpio_alt,
    input wire logic [5:0] o_pin,
    input wire logic [5:0] o_alt_pin,
    input wire logic [5:0] o_pwm
);
    // ****************
    // shadow state
    // ****************
    logic [7:0] ctl_reg, sel_reg, alt_reg;
    logic [2:0] st_reg;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // settle counter: outputs lag a write by a few cycles
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ctl_reg <= 8'h00;
            sel_reg <= 8'h00;
            alt_reg <= 8'h00;
            st_reg <= 3'h0;
        end else begin
            if (i_wr && i_addr == SCP_ADDR_CONTROL_ONE) ctl_reg <= i_wdata;
            if (i_wr && i_addr == SCP_ADDR_PIN_SEL) sel_reg <= i_wdata;
            if (i_wr && i_addr == SCP_ADDR_ALT_PIN_SEL) alt_reg <= i_wdata;
            st_reg <= i_wr ? 3'h0 : st_reg + {2'h0, st_reg != 3'h7};
        end
    end
    rst_zero_a: assert property (!$past(i_resetn) |-> o_pwm == 6'h00 && o_rdata == 8'h00)
        else $error("outputs not zero after reset");
    ctl_read_a: assert property (i_rd && i_addr == SCP_ADDR_CONTROL_ONE |=> o_rdata == ctl_reg)
        else $error("control read back wrong");
    pin_read_a: assert property (i_rd && i_addr == SCP_ADDR_PIN_SEL |=> o_rdata == (sel_reg & SCP_PIN_MASK))
        else $error("pin select read back wrong");
    alt_read_a: assert property (i_rd && i_addr == SCP_ADDR_ALT_PIN_SEL |=> o_rdata == (alt_reg & SCP_ALT_PIN_MASK))
        else $error("alt select read back wrong");
    pin_gpio_a: assert property ($past(i_resetn) && st_reg > 1 |-> ((o_pin ^ $past(i_gpio_pin)) & ~sel_reg[5:0]) == 6'h00)
        else $error("unrouted pin lost its gpio level");
    alt_gpio_a: assert property ($past(i_resetn) && st_reg > 1 |->
        ((o_alt_pin ^ $past(i_gpio_alt)) & ~(alt_reg[5:0] & SCP_ALT_PIN_MASK[5:0])) == 6'h00)
        else $error("unrouted alt pin lost its gpio level");
    compl_excl_a: assert property (ctl_reg[7:6] == SCP_MODE_COMPL && st_reg > 3 |-> !(o_pwm[0] && o_pwm[1]))
        else $error("complementary pair both high");
    sync_copy_a: assert property (ctl_reg[7:6] == SCP_MODE_SYNC && st_reg > 3 |->
        o_pwm[1] == o_pwm[0] && o_pwm[3] == o_pwm[2] && o_pwm[5] == o_pwm[4])
        else $error("synchronized odd channel differs");
    cover property (i_rd && i_addr == SCP_ADDR_CONTROL_ONE);
    cover property (ctl_reg[7:6] == SCP_MODE_COMPL && $rose(o_pwm[1]));
    cover property (sel_reg[5] && o_pin[5]);
endmodule
`default_nettype wire

// ### bench/scp_gpio_drv.sv
// Purpose: general i/o drivers behind the shared pins
// Assumes: same clock as the core
// Notes: levels flip every cycle so a stuck route shows
`timescale 1ns/1ps
`default_nettype none
module scp_gpio_drv (
    input wire logic i_clk,
    output logic [5:0] o_gpio_pin,
    output logic [5:0] o_gpio_alt
);
    initial begin
        o_gpio_pin = 6'h15;
        o_gpio_alt = 6'h2a;
    end
    always @(posedge i_clk) begin
        o_gpio_pin <= ~o_gpio_pin;
        o_gpio_alt <= ~o_gpio_alt;
    end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: self-checking bench for scp_core
// Assumes: 20 MHz clock, gpio drivers on the pins
// Notes: waveform counts taken from the third full cycle
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_top;
    import scp_pkg::*;
    logic i_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic [5:0] i_gpio_pin, i_gpio_alt, o_pin, o_alt_pin, o_pwm;
    int err_total = 0, checks = 0, hi, per;
    always #25 i_clk = ~i_clk;
    scp_core dut (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_gpio_pin, .i_gpio_alt,
        .o_pin, .o_alt_pin, .o_pwm);
    scp_gpio_drv load (.i_clk, .o_gpio_pin(i_gpio_pin), .o_gpio_alt(i_gpio_alt));
    // ****************
    // bus tasks
    // ****************
    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHK("rdata", e, o_rdata)
    endtask
    // both codes on adjacent edges: an idle cycle between them relocks
    task automatic unlock;
        @(posedge i_clk);
        i_addr <= SCP_ADDR_TIMED_ACCESS;
        i_wdata <= SCP_UNLOCK_FIRST;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wdata <= SCP_UNLOCK_SECOND;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // bounded waits: a dead channel ends with odd counts, not a hang
    task automatic meas(input int ch);
        int n;
        n = 0;
        while (o_pwm[ch] !== 1'b0 && n < 400) begin tick; n++; end
        while (o_pwm[ch] !== 1'b1 && n < 800) begin tick; n++; end
        hi = 0;
        per = 0;
        while (o_pwm[ch] === 1'b1 && per < 400) begin tick; hi++; per++; end
        while (o_pwm[ch] === 1'b0 && per < 400) begin tick; per++; end
    endtask
    task automatic pchk(input int ch, input int ehi, input int eper);
        meas(ch);
        meas(ch);
        if (ehi >= 0) `CHK("high", ehi, hi)
        `CHK("period", eper, per)
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        repeat (20000) @(posedge i_clk);
        err_total++;
        close_out;
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(SCP_ADDR_ALT_PIN_SEL, 8'h00);
        rd(SCP_ADDR_PIN_SEL, 8'h00);
        rd(SCP_ADDR_CONTROL_ONE, 8'h00);
        rd(SCP_ADDR_DT_ENABLE, 8'h00);
        wr(SCP_ADDR_PIN_SEL, 8'hff);
        rd(SCP_ADDR_PIN_SEL, SCP_PIN_MASK);
        wr(SCP_ADDR_ALT_PIN_SEL, 8'hff);
        rd(SCP_ADDR_ALT_PIN_SEL, SCP_ALT_PIN_MASK);
        wr(SCP_ADDR_CONTROL_ONE, 8'hc7);
        rd(SCP_ADDR_CONTROL_ONE, 8'hc7);
        wr(SCP_ADDR_CONTROL_ONE, 8'h00);
        rd(8'h00, 8'h00);
        wr16(SCP_ADDR_PERIOD_LOW, 16'h0009);
        wr16(SCP_ADDR_DUTY_BASE, 16'h0003);
        wr16(SCP_ADDR_DUTY_BASE + 8'h02, 16'h0005);
        pchk(0, 3, 10);
        pchk(1, 5, 10);
        wr(SCP_ADDR_CONTROL_ONE, 8'h01);
        pchk(0, 6, 20);
        wr(SCP_ADDR_CONTROL_ONE, 8'h40);
        pchk(1, 7, 10);
        wr(SCP_ADDR_CONTROL_ONE, 8'h80);
        pchk(1, 3, 10);
        wr(SCP_ADDR_DT_COUNT, 8'h05);
        rd(SCP_ADDR_DT_COUNT, 8'h00);
        unlock;
        wr(SCP_ADDR_DT_COUNT, 8'h05);
        rd(SCP_ADDR_DT_COUNT, 8'h05);
        unlock;
        wr(SCP_ADDR_DT_ENABLE, 8'h01);
        rd(SCP_ADDR_DT_ENABLE, 8'h01);
        wr16(SCP_ADDR_PERIOD_LOW, 16'h0013);
        wr16(SCP_ADDR_DUTY_BASE, 16'h000a);
        wr16(SCP_ADDR_DUTY_BASE + 8'h04, 16'h000a);
        wr(SCP_ADDR_CONTROL_ONE, 8'h40);
        pchk(0, 4, 20);
        pchk(1, 4, 20);
        pchk(3, 10, 20);
        wr(SCP_ADDR_CONTROL_ONE, 8'h00);
        pchk(0, 10, 20);
        wr(SCP_ADDR_CONTROL_ONE, 8'h10);
        pchk(0, -1, 38);
        wr16(SCP_ADDR_DUTY_BASE + 8'h0a, 16'hffff);
        wr(SCP_ADDR_PIN_SEL, 8'h30);
        wr(SCP_ADDR_ALT_PIN_SEL, 8'h20);
        repeat (4) tick;
        `CHK("pin", 2'b10, o_pin[5:4])
        `CHK("alt pin", 1'b1, o_alt_pin[5])
        close_out;
    end
endmodule
bind scp_core scp_core_chk chk (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_gpio_pin,
    .i_gpio_alt, .o_pin, .o_alt_pin, .o_pwm);
`default_nettype wire
